// ### src/dsr_addr_step.sv
// Address stepping by transfer size and stepping mode.
`timescale 1ns/10ps
module dsr_addr_step
	import dsr_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [1:0] mode,
	input wire logic [1:0] size,
	output logic [31:0] next_addr
);
	logic [31:0] delta;

	always_comb begin
		// Sizes above a longword are treated as a longword.
		if (size == SIZE_BYTE) begin
			delta = 32'h0000_0001; // [RULE_12]
		end else if (size == SIZE_WORD) begin
			delta = 32'h0000_0002; // [RULE_17]
		end else begin
			delta = 32'h0000_0004; // [RULE_17]
		end
		if (mode == MODE_INC) begin
			next_addr = addr + delta;
		end else if (mode == MODE_DEC) begin
			next_addr = addr - delta;
		end else begin
			next_addr = addr;
		end
	end
endmodule : dsr_addr_step

// ### src/dsr_group_count.sv
// Counter of transfers within one reload group.
`timescale 1ns/10ps
module dsr_group_count
	import dsr_pkg::*;
#(
	parameter int GROUP = GROUP_LEN
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic step,
	output logic [$clog2(GROUP)-1:0] pos,
	output logic last
);
	localparam logic [$clog2(GROUP)-1:0] TOP = ($clog2(GROUP))'(GROUP - 1);

	assign last = (pos == TOP);

	// Clear wins over a step so a stopped group never resumes half done.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos <= '0;
		end else if (clear) begin
			pos <= '0; // [RULE_16]
		end else if (step) begin
			pos <= last ? '0 : pos + 1'b1;
		end
	end
endmodule : dsr_group_count

// ### src/dsr_pkg.sv
// Constants, register map and types of the source-reload DMA channel.
// Behaviour
// [RULE_01] With reload on, source address returns to its programmed value every four transfers.
// [RULE_02] With reload on, stop after each fourth transfer and drop the bus request.
// [RULE_03] With reload off, keep the bus and keep advancing the source address; the channel keeps the bus only with burst mode on.
// [RULE_04] Reload halt clears the requester's flag; no such clear mid-count without reload.
// [RULE_05] End interrupt only when count reaches zero and enable is set.
// [RULE_06] Count reaching zero clears the requester's flag with or without reload.
// [RULE_07] After a reload halt the peripheral must request again for the next group.
// [RULE_08] Software should pick burst mode whenever reload is on.
// [RULE_09] Software should program a count that is a multiple of four with reload.
// [RULE_10] Count counts single transfers, so 128 gives 32 groups of four.
// [RULE_11] Burst mode holds the bus between transfers of a group.
// [RULE_12] Byte size with increment steps source and destination by one.
// [RULE_13] Destination keeps its own stepping across groups, untouched by reload.
// [RULE_14] Reload is on when the reload-on bit of the channel control is one.
// [RULE_15] Count decrements by one after every transfer.
// [RULE_16] Group counter clears on disable, end, NMI, address error, standby; registers kept.
// [RULE_17] Reload works for 8, 16 and 32 bit sizes.
// [RULE_18] Each software write of the source address is copied into a reload shadow.
package dsr_pkg;
	localparam logic [7:0] OFS_SRC = 8'h00;
	localparam logic [7:0] OFS_DST = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
	localparam logic [7:0] OFS_OPER = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_RELOAD = 8'h1C;
	localparam int CTRL_CH_EN = 0;
	localparam int CTRL_END_FLAG = 1;
	localparam int CTRL_INT_EN = 2;
	localparam int CTRL_RELOAD = 3;
	localparam int CTRL_BURST = 4;
	localparam int CTRL_SIZE = 5;
	localparam int CTRL_SRC_MODE = 8;
	localparam int CTRL_DST_MODE = 10;
	localparam int OPER_ENABLE = 0;
	localparam int OPER_NMI = 1;
	localparam int OPER_ADDR_ERR = 2;
	localparam int IRQ_END = 0;
	localparam int IRQ_ADDR_ERR = 1;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] MODE_FIXED = 2'h0;
	localparam logic [1:0] MODE_INC = 2'h1;
	localparam logic [1:0] MODE_DEC = 2'h2;
	localparam int GROUP_LEN = 4;
	typedef enum logic [1:0] {
		S_IDLE,
		S_WAIT,
		S_MOVE
	} dsr_state_type;
endpackage : dsr_pkg

// ### src/dsr_top.sv
// Channel with source-address reload, APB registers and bus request logic.
`timescale 1ns/10ps
module dsr_top
	import dsr_pkg::*;
#(
	parameter int CNT_W = 24
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TREQ,
	output logic REQ_CLEAR,
	output logic BUS_REQ,
	input wire logic BUS_GRANT,
	output logic XFER_VALID,
	output logic [31:0] SRC_ADDR,
	output logic [31:0] DST_ADDR,
	output logic [1:0] XFER_SIZE,
	input wire logic XFER_DONE,
	input wire logic ADDR_ERR,
	input wire logic NMI_PIN,
	input wire logic STANDBY,
	output logic IRQ
);
	logic [31:0] source_address_reg;
	logic [31:0] dest_address_reg;
	logic [31:0] reload_shadow;
	logic [CNT_W-1:0] transfer_count_reg;
	logic channel_enable;
	logic transfer_end_flag;
	logic end_interrupt_enable;
	logic reload_on;
	logic burst_mode;
	logic [1:0] xfer_size;
	logic [1:0] src_mode;
	logic [1:0] dst_mode;
	logic controller_enable;
	logic nmi_flag;
	logic addr_error_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic nmi_meta;
	logic nmi_sync;
	logic nmi_prev;
	logic [31:0] next_src;
	logic [31:0] next_dst;
	logic [1:0] grp_pos;
	logic grp_last;
	logic [31:0] rd_val;
	logic rd_hit;
	dsr_state_type state;

	////////////////////////////////////////////////////////////////////////
	// Bus slave.

	logic wr;
	logic wr_src;
	logic wr_dst;
	logic wr_cnt;
	logic wr_ctrl;
	logic wr_oper;
	logic wr_stat;
	logic wr_mask;

	assign wr = PSEL && PENABLE && PWRITE;
	assign wr_src = wr && (PADDR == OFS_SRC);
	assign wr_dst = wr && (PADDR == OFS_DST);
	assign wr_cnt = wr && (PADDR == OFS_COUNT);
	assign wr_ctrl = wr && (PADDR == OFS_CTRL);
	assign wr_oper = wr && (PADDR == OFS_OPER);
	assign wr_stat = wr && (PADDR == OFS_IRQ_STAT);
	assign wr_mask = wr && (PADDR == OFS_IRQ_MASK);

	always_comb begin
		rd_hit = 1'b1;
		rd_val = RST_WORD;
		if (PADDR == OFS_SRC) begin
			rd_val = source_address_reg;
		end else if (PADDR == OFS_DST) begin
			rd_val = dest_address_reg;
		end else if (PADDR == OFS_COUNT) begin
			rd_val[CNT_W-1:0] = transfer_count_reg;
		end else if (PADDR == OFS_CTRL) begin
			rd_val[CTRL_CH_EN] = channel_enable;
			rd_val[CTRL_END_FLAG] = transfer_end_flag;
			rd_val[CTRL_INT_EN] = end_interrupt_enable;
			rd_val[CTRL_RELOAD] = reload_on;
			rd_val[CTRL_BURST] = burst_mode;
			rd_val[CTRL_SIZE+:2] = xfer_size;
			rd_val[CTRL_SRC_MODE+:2] = src_mode;
			rd_val[CTRL_DST_MODE+:2] = dst_mode;
		end else if (PADDR == OFS_OPER) begin
			rd_val[OPER_ENABLE] = controller_enable;
			rd_val[OPER_NMI] = nmi_flag;
			rd_val[OPER_ADDR_ERR] = addr_error_flag;
		end else if (PADDR == OFS_IRQ_STAT) begin
			rd_val[1:0] = irq_status;
		end else if (PADDR == OFS_IRQ_MASK) begin
			rd_val[1:0] = irq_mask;
		end else if (PADDR == OFS_RELOAD) begin
			rd_val = reload_shadow;
		end else begin
			rd_hit = 1'b0;
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !rd_hit;

	// Read data is caught in the setup cycle so it comes from a flip-flop.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PRDATA <= RST_WORD;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel sequencing.

	logic done_evt;
	logic last_xfer;
	logic end_set;
	logic reload_hit;
	logic src_reload;
	logic halt_src;
	logic start;
	logic grp_clear;

	assign done_evt = (state == S_MOVE) && XFER_DONE;
	assign last_xfer = (transfer_count_reg == CNT_W'(1));
	assign end_set = done_evt && last_xfer;
	assign reload_hit = done_evt && reload_on && grp_last && !last_xfer;
	// The last group of a count reloads the source as well.
	assign src_reload = done_evt && reload_on && grp_last;
	assign halt_src = !controller_enable || !channel_enable || nmi_flag
		|| addr_error_flag || STANDBY;
	// A pending flag clear blocks a restart on the request being cleared.
	assign start = !halt_src && !transfer_end_flag && !REQ_CLEAR && TREQ
		&& (transfer_count_reg != '0); // [RULE_02]
	assign grp_clear = halt_src || end_set || transfer_end_flag; // [RULE_16]

	dsr_group_count #(
		.GROUP(GROUP_LEN)
	) u_group (
		.clk(CLK),
		.rst(RST),
		.clear(grp_clear),
		.step(done_evt),
		.pos(grp_pos),
		.last(grp_last)
	);

	dsr_addr_step u_src_step (
		.addr(source_address_reg),
		.mode(src_mode),
		.size(xfer_size),
		.next_addr(next_src)
	);

	dsr_addr_step u_dst_step (
		.addr(dest_address_reg),
		.mode(dst_mode),
		.size(xfer_size),
		.next_addr(next_dst)
	);

	// Halts are honoured at once while waiting for the grant, but only at the end of a transfer already on the bus.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE: begin
					if (start) begin
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (halt_src) begin
						state <= S_IDLE;
					end else if (BUS_GRANT) begin
						state <= S_MOVE;
					end
				end
				S_MOVE: begin
					if (XFER_DONE) begin
						if (end_set || reload_hit) begin
							state <= S_IDLE; // [RULE_02]
						end else if (halt_src || !burst_mode) begin
							state <= S_IDLE;
						end else begin
							state <= S_MOVE; // [RULE_03] [RULE_11]
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	assign BUS_REQ = (state != S_IDLE);
	assign XFER_VALID = (state == S_MOVE);
	assign SRC_ADDR = source_address_reg;
	assign DST_ADDR = dest_address_reg;
	assign XFER_SIZE = xfer_size;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			REQ_CLEAR <= 1'b0;
		end else begin
			REQ_CLEAR <= end_set || reload_hit; // [RULE_04] [RULE_06]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address and count registers.

	// A software write wins over the hardware update in the same cycle.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			source_address_reg <= RST_WORD;
		end else if (wr_src) begin
			source_address_reg <= PWDATA;
		end else if (src_reload) begin
			source_address_reg <= reload_shadow; // [RULE_01] [RULE_14]
		end else if (done_evt) begin
			source_address_reg <= next_src; // [RULE_03] [RULE_12]
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			reload_shadow <= RST_WORD;
		end else if (wr_src) begin
			reload_shadow <= PWDATA; // [RULE_18]
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dest_address_reg <= RST_WORD;
		end else if (wr_dst) begin
			dest_address_reg <= PWDATA;
		end else if (done_evt) begin
			dest_address_reg <= next_dst; // [RULE_13] [RULE_12]
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			transfer_count_reg <= '0;
		end else if (wr_cnt) begin
			transfer_count_reg <= PWDATA[CNT_W-1:0];
		end else if (done_evt) begin
			transfer_count_reg <= transfer_count_reg - 1'b1; // [RULE_15] [RULE_10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, operation and interrupt registers.

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			channel_enable <= 1'b0;
			end_interrupt_enable <= 1'b0;
			reload_on <= 1'b0;
			burst_mode <= 1'b0;
			xfer_size <= SIZE_BYTE;
			src_mode <= MODE_FIXED;
			dst_mode <= MODE_FIXED;
		end else if (wr_ctrl) begin
			channel_enable <= PWDATA[CTRL_CH_EN];
			end_interrupt_enable <= PWDATA[CTRL_INT_EN];
			reload_on <= PWDATA[CTRL_RELOAD]; // [RULE_14]
			burst_mode <= PWDATA[CTRL_BURST];
			xfer_size <= PWDATA[CTRL_SIZE+:2];
			src_mode <= PWDATA[CTRL_SRC_MODE+:2];
			dst_mode <= PWDATA[CTRL_DST_MODE+:2];
		end
	end

	// Flags are cleared by writing zero; a hardware set in that cycle wins.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			transfer_end_flag <= 1'b0;
		end else if (end_set) begin
			transfer_end_flag <= 1'b1;
		end else if (wr_ctrl && !PWDATA[CTRL_END_FLAG]) begin
			transfer_end_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			nmi_meta <= 1'b0;
			nmi_sync <= 1'b0;
			nmi_prev <= 1'b0;
		end else begin
			nmi_meta <= NMI_PIN;
			nmi_sync <= nmi_meta;
			nmi_prev <= nmi_sync;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			controller_enable <= 1'b0;
			nmi_flag <= 1'b0;
			addr_error_flag <= 1'b0;
		end else begin
			if (wr_oper) begin
				controller_enable <= PWDATA[OPER_ENABLE];
			end
			if (nmi_sync && !nmi_prev) begin
				nmi_flag <= 1'b1;
			end else if (wr_oper && !PWDATA[OPER_NMI]) begin
				nmi_flag <= 1'b0;
			end
			if (ADDR_ERR) begin
				addr_error_flag <= 1'b1;
			end else if (wr_oper && !PWDATA[OPER_ADDR_ERR]) begin
				addr_error_flag <= 1'b0;
			end
		end
	end

	logic [1:0] irq_set;

	assign irq_set[IRQ_END] = end_set && end_interrupt_enable; // [RULE_05]
	assign irq_set[IRQ_ADDR_ERR] = ADDR_ERR;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			irq_status <= RST_IRQ;
		end else if (wr_stat) begin
			irq_status <= (irq_status & ~PWDATA[1:0]) | irq_set;
		end else begin
			irq_status <= irq_status | irq_set;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			irq_mask <= RST_IRQ;
		end else if (wr_mask) begin
			irq_mask <= PWDATA[1:0];
		end
	end

	assign IRQ = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence s_group_end;
		reload_hit && !wr_src;
	endsequence

	property p_reload;
		s_group_end |=> source_address_reg == $past(reload_shadow);
	endproperty
	a_reload: assert property (p_reload) // [RULE_01]
		else $error("Source not reloaded at group end.");

	property p_halt;
		s_group_end |=> !BUS_REQ ##1 !BUS_REQ;
	endproperty
	a_halt: assert property (p_halt) // [RULE_02]
		else $error("Bus request kept after group end.");

	property p_keep;
		done_evt && burst_mode && !reload_on && !last_xfer && !halt_src
		|=> XFER_VALID && BUS_REQ;
	endproperty
	a_keep: assert property (p_keep) // [RULE_03]
		else $error("Burst without reload released the bus.");

	property p_clear;
		REQ_CLEAR |-> $past(end_set) || $past(reload_hit);
	endproperty
	a_clear: assert property (p_clear) // [RULE_04]
		else $error("Request flag cleared without cause.");

	property p_end_clear;
		end_set |=> REQ_CLEAR && transfer_end_flag;
	endproperty
	a_end_clear: assert property (p_end_clear) // [RULE_06]
		else $error("Count end without request flag clear.");

	property p_irq;
		$rose(irq_status[IRQ_END]) |->
			$past(end_set) && $past(end_interrupt_enable);
	endproperty
	a_irq: assert property (p_irq) // [RULE_05]
		else $error("End interrupt raised without count end.");

	property p_count;
		done_evt && !wr_cnt |=>
			transfer_count_reg == $past(transfer_count_reg) - 1'b1;
	endproperty
	a_count: assert property (p_count) // [RULE_15]
		else $error("Count did not drop by one.");

	property p_dst;
		(s_group_end and !wr_dst) |=> dest_address_reg == $past(next_dst);
	endproperty
	a_dst: assert property (p_dst) // [RULE_13]
		else $error("Destination disturbed by reload.");

	property p_group;
		grp_clear |=> grp_pos == 2'h0 && !grp_last;
	endproperty
	a_group: assert property (p_group) // [RULE_16]
		else $error("Group counter not cleared.");
endmodule : dsr_top

// ### verif/dsr_partner.sv
// Bus arbiter and requesting peripheral that face the reload channel.
`timescale 1ns/10ps
module dsr_partner
	import dsr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic raise,
	input wire logic slow,
	input wire logic bus_req,
	input wire logic xfer_valid,
	input wire logic req_clear,
	output logic treq,
	output logic bus_grant,
	output logic xfer_done
);
	logic [1:0] gdly;
	logic [1:0] wcnt;
	////////////////////////////////////////////////////////////////////////
	// The flag stays up until the channel clears it, so each group needs a fresh raise.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			treq <= 1'b0;
		end else if (raise) begin
			treq <= 1'b1;
		end else if (req_clear) begin
			treq <= 1'b0;
		end
	end
	// A slow arbiter grants three cycles late and then holds the grant.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gdly <= 2'h0;
		end else if (!bus_req) begin
			gdly <= 2'h0;
		end else if (gdly != 2'h3) begin
			gdly <= gdly + 2'h1;
		end
	end
	assign bus_grant = bus_req && (!slow || gdly == 2'h3);
	// A slow bus stretches every transfer by two wait cycles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wcnt <= 2'h0;
		end else if (!xfer_valid || xfer_done) begin
			wcnt <= 2'h0;
		end else begin
			wcnt <= wcnt + 2'h1;
		end
	end
	assign xfer_done = xfer_valid && (!slow || wcnt == 2'h2);
endmodule : dsr_partner

// ### verif/testbench.sv
// Self-checking bench for the source-reload channel.
`timescale 1ns/10ps
module testbench import dsr_pkg::*;;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, src_addr, dst_addr, q;
	logic treq, req_clear, bus_req, bus_grant, xfer_valid, xfer_done;
	logic aerr, irq, raise, slow, reload, e, nmi, stby;
	logic [1:0] xfer_size, exp_sz;
	logic [31:0] sbase, exp_src, exp_dst, sstep, dstep, k, n_clr;
	int error_cnt, n_tests;
	dsr_top #(.CNT_W(24)) DUT (.CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TREQ(treq),
		.REQ_CLEAR(req_clear), .BUS_REQ(bus_req), .BUS_GRANT(bus_grant),
		.XFER_VALID(xfer_valid), .SRC_ADDR(src_addr), .DST_ADDR(dst_addr),
		.XFER_SIZE(xfer_size), .XFER_DONE(xfer_done), .ADDR_ERR(aerr),
		.NMI_PIN(nmi), .STANDBY(stby), .IRQ(irq));
	dsr_partner u_partner (.clk(clk), .rst(rst), .raise(raise), .slow(slow),
		.bus_req(bus_req), .xfer_valid(xfer_valid), .req_clear(req_clear),
		.treq(treq), .bus_grant(bus_grant), .xfer_done(xfer_done));
	////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic tmo(input string m);
		error_cnt++;
		$display("mismatch t=%0t timeout %s", $time, m);
		close_out();
	endtask : tmo
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) tmo("pready");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, x, m);
	endtask : rd
	task automatic chk_irq(input logic x);
		@(posedge clk);
		chk({31'h0000_0000, irq}, {31'h0000_0000, x}, "irq");
	endtask : chk_irq
	////////////////////////////////////////////////////////////////////////
	// Expected addresses advance on every completed transfer.
	always @(posedge clk) begin
		if (xfer_valid === 1'b1 && xfer_done === 1'b1) begin
			chk(src_addr, exp_src, "src");
			chk(dst_addr, exp_dst, "dst");
			chk({30'h0000_0000, xfer_size}, {30'h0000_0000, exp_sz}, "size");
			exp_src = exp_src + sstep;
			exp_dst = exp_dst + dstep;
			k = k + 32'h0000_0001;
			if (reload && k[1:0] == 2'h0) exp_src = sbase;
		end
		if (req_clear === 1'b1) n_clr = n_clr + 32'h0000_0001;
	end
	task automatic run(input logic rl, int_en, sl, input logic [1:0] sz, dm,
			input logic [31:0] cnt);
		logic [31:0] c;
		int g, ng, i;
		sbase = 32'hFFFF_83F0;
		exp_src = sbase;
		exp_dst = 32'hFFFF_F000;
		sstep = 32'h0000_0001 << sz;
		dstep = (dm == MODE_DEC) ? -sstep : sstep;
		reload = rl;
		exp_sz = sz;
		k = 32'h0000_0000;
		n_clr = 32'h0000_0000;
		slow <= sl;
		c = 32'h0000_0000;
		c[CTRL_CH_EN] = 1'b1;
		c[CTRL_INT_EN] = int_en;
		c[CTRL_RELOAD] = rl;
		c[CTRL_BURST] = 1'b1;
		c[CTRL_SIZE +: 2] = sz;
		c[CTRL_SRC_MODE +: 2] = MODE_INC;
		c[CTRL_DST_MODE +: 2] = dm;
		apb(1'b1, OFS_SRC, sbase);
		apb(1'b1, OFS_DST, exp_dst);
		apb(1'b1, OFS_COUNT, cnt);
		rd(OFS_RELOAD, sbase, "shadow");
		apb(1'b1, OFS_CTRL, c);
		ng = rl ? int'(cnt) / 4 : 1;
		for (g = 0; g < ng; g++) begin
			@(posedge clk);
			raise <= 1'b1;
			@(posedge clk);
			raise <= 1'b0;
			for (i = 0; i < 300; i++) begin
				@(posedge clk);
				if (req_clear === 1'b1) break;
			end
			if (i == 300) tmo("group end");
			chk({31'h0000_0000, bus_req}, 32'h0000_0000, "bus");
			chk(k, rl ? 32'(4 * (g + 1)) : cnt, "moves");
			rd(OFS_SRC, exp_src, "src reg");
			rd(OFS_COUNT, cnt - k, "count");
			rd(OFS_DST, exp_dst, "dst reg");
			chk_irq(int_en && g == ng - 1);
		end
		chk(n_clr, 32'(ng), "flag clears");
		rd(OFS_CTRL, c | 32'h0000_0002, "end flag");
		apb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		chk_irq(1'b0);
	endtask : run
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		int i;
		{rst, psel, penable, pwrite, aerr, raise, slow, reload, nmi, stby} = 10'h200;
		exp_sz = SIZE_BYTE;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{error_cnt, n_tests} = 0;
		{k, n_clr, sbase, exp_src, exp_dst, sstep, dstep} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL, RST_WORD, "ctrl reset");
		rd(OFS_COUNT, RST_WORD, "count reset");
		apb(1'b1, 8'h20, 32'h0000_0001);
		chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped");
		apb(1'b1, OFS_RELOAD, 32'h0000_0055);
		rd(OFS_RELOAD, RST_WORD, "shadow read only");
		apb(1'b1, OFS_OPER, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		run(1'b1, 1'b1, 1'b0, SIZE_BYTE, MODE_INC, 32'h0000_0080);
		run(1'b1, 1'b0, 1'b1, SIZE_WORD, MODE_DEC, 32'h0000_0008);
		run(1'b1, 1'b1, 1'b0, 2'h2, MODE_INC, 32'h0000_0004);
		run(1'b0, 1'b1, 1'b1, SIZE_BYTE, MODE_INC, 32'h0000_0008);
		// Standby holds a pending request off; the count then runs out.
		apb(1'b1, OFS_COUNT, 32'h0000_0004);
		apb(1'b1, OFS_CTRL, 32'h0000_0511);
		stby <= 1'b1;
		raise <= 1'b1;
		@(posedge clk);
		raise <= 1'b0;
		repeat (4) @(posedge clk);
		chk({31'h0000_0000, bus_req}, 32'h0000_0000, "standby");
		stby <= 1'b0;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (req_clear === 1'b1) break;
		end
		if (i == 300) tmo("standby end");
		chk(k, 32'h0000_000C, "moves after standby");
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		@(posedge clk);
		aerr <= 1'b1;
		@(posedge clk);
		aerr <= 1'b0;
		rd(OFS_IRQ_STAT, 32'h0000_0002, "error status");
		chk_irq(1'b0);
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
		chk_irq(1'b1);
		apb(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
		chk_irq(1'b0);
		nmi <= 1'b1;
		repeat (4) @(posedge clk);
		nmi <= 1'b0;
		rd(OFS_OPER, 32'h0000_0007, "nmi flag");
		apb(1'b1, OFS_OPER, 32'h0000_0001);
		rd(OFS_OPER, 32'h0000_0001, "flags cleared");
		close_out();
	end
endmodule : testbench
